/* File: src/dpsp_pkg.sv */
// Purpose: constants for the dual protocol serial port
// Assumes: serial pins sampled by a 100 MHz system clock
// Notes:   register index 0 holds id on read and strobes on write
//
// Contract
// - listen to both, commit once, hold mode
// - strobe rising first selects legacy protocol
// - clock rising first selects open protocol
// - serial clock up to 50 MHz
// - legacy frame: direction, six address, 24 data
// - legacy first bit low means write
// - legacy address on rising edges 2 to 7
// - legacy write data on rising edges 8 to 31
// - legacy first bit high means read
// - legacy read data out on edges 8 to 31
// - lock indicator returns on 32nd rising edge
// - lock indicator kept until first read bit
// - open frame: 24 data bits shifted first
// - open register address on edges 25 to 29
// - open chip address on edges 30 to 32
// - open word committed on strobe rising edge
// - register 0: id read, address/reset write
// - open frames shift out selected register
// - unknown chip address tristates output line
package dpsp_pkg;

  // ****************************************************
  // frame layout
  // ****************************************************
  localparam int unsigned FRAME_BITS     = 32;
  localparam int unsigned DATA_BITS      = 24;
  localparam int unsigned LEG_ADDR_BITS  = 6;
  localparam int unsigned OPEN_ADDR_BITS = 5;
  localparam int unsigned CHIP_BITS      = 3;
  localparam logic [5:0]  LEG_DATA_FIRST = 6'h07;  // bits already seen before first data edge
  localparam logic [5:0]  LEG_LAST_EDGE  = 6'h1f;  // count after 31st rising edge
  localparam logic [5:0]  FULL_COUNT     = 6'h20;

  // ****************************************************
  // register map
  // ****************************************************
  localparam logic [4:0]  REG_ID_STROBE  = 5'h00;
  localparam int unsigned SWRST_BIT      = 5;
  localparam logic [4:0]  RD_ADDR_RESET  = 5'h00;
  localparam logic [2:0]  CHIP_ADDR_RST  = 3'h0;
  // arbitrary neutral identification value
  localparam logic [23:0] CHIP_ID_RST    = 24'h123456;

  // ****************************************************
  // types
  // ****************************************************
  typedef enum logic [1:0] {
    DPSP_UNDECIDED = 2'b00,
    DPSP_LEGACY    = 2'b01,
    DPSP_OPEN      = 2'b11
  } dpsp_mode_t;

endpackage : dpsp_pkg

/* File: src/dpsp_port.sv */
// Purpose: dual protocol serial control port, device side
// Assumes: host keeps lines low at power-up, serial clock at most 50 MHz
// Notes:   serial pins oversampled by clk; outputs are registered
`timescale 1ns/1ns
`default_nettype none
module dpsp_port (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        frame_strobe,
  input  wire logic        serial_clk,
  input  wire logic        serial_in,
  input  wire logic        lock_indicator,
  input  wire logic [23:0] reg_rdata,
  input  wire logic [2:0]  chip_addr,
  output logic             serial_out,
  output logic             serial_out_oe_n,
  output logic [5:0]       reg_addr,
  output logic [23:0]      reg_wdata,
  output logic             reg_we,
  output logic             soft_reset,
  output logic [4:0]       open_rd_addr,
  output logic [1:0]       proto_mode
);

  // ****************************************************
  // input synchronisers
  // ****************************************************
  logic fs_lvl;
  logic fs_rise;
  logic fs_fall;
  logic sc_lvl;
  logic sc_rise;
  logic sc_fall;
  logic si_lvl;

  // link rate bound: each serial clock phase
  // must span at least one clk period to be seen
  dpsp_sync u_sync_fs (
    .clk   (clk),
    .rst_n (rst_n),
    .pin   (frame_strobe),
    .level (fs_lvl),
    .rise  (fs_rise),
    .fall  (fs_fall)
  );

  dpsp_sync u_sync_sc (
    .clk   (clk),
    .rst_n (rst_n),
    .pin   (serial_clk),
    .level (sc_lvl),
    .rise  (sc_rise),
    .fall  (sc_fall)
  );

  dpsp_sync u_sync_si (
    .clk   (clk),
    .rst_n (rst_n),
    .pin   (serial_in),
    .level (si_lvl),
    .rise  (),
    .fall  ()
  );

  // ****************************************************
  // state
  // ****************************************************
  typedef struct packed {
    dpsp_pkg::dpsp_mode_t mode;
    logic [5:0]           cnt;
    logic [31:0]          shreg;
    logic                 is_read;
    logic [23:0]          tx;
    logic                 tx_on;
    logic                 drive_n;
    logic                 out;
    logic                 oe_n;
    logic [5:0]           addr;
    logic [23:0]          wdata;
    logic                 we;
    logic                 srst;
    logic [4:0]           rd_addr;
  } dpsp_st_t;

  dpsp_st_t st_q;
  dpsp_st_t st_d;

  // read mux for register 0 against outside registers
  function automatic logic [23:0] rd_word(input logic [5:0] a, input logic [23:0] ext);
    rd_word = (a == {1'b0, dpsp_pkg::REG_ID_STROBE}) ? dpsp_pkg::CHIP_ID_RST : ext;
  endfunction : rd_word

  // ****************************************************
  // next state
  // ****************************************************
  always_comb begin
    logic [31:0] sh;
    logic [5:0]  a6;
    logic [4:0]  a5;
    logic [23:0] ow;
    logic [23:0] lw;
    sh    = '0;
    a6    = '0;
    a5    = '0;
    // words for the stored open read address and the legacy frame address
    ow    = rd_word({1'b0, st_q.rd_addr}, reg_rdata);
    lw    = rd_word(st_q.addr, reg_rdata);
    st_d      = st_q;
    st_d.we   = 1'b0;
    st_d.srst = 1'b0;

    if (st_q.mode == dpsp_pkg::DPSP_UNDECIDED) begin
      if (fs_rise) begin
        st_d.mode = dpsp_pkg::DPSP_LEGACY;
        st_d.cnt  = '0;
      end else if (sc_rise) begin
        st_d.mode  = dpsp_pkg::DPSP_OPEN;
        st_d.cnt   = 6'h01;
        st_d.shreg = {31'h0, si_lvl};
        // first open bit goes out on the very first rise
        st_d.tx    = ow;
        st_d.out   = ow[23];
        st_d.tx_on = 1'b1;
      end
    end else if (st_q.mode == dpsp_pkg::DPSP_LEGACY) begin
      if (!fs_lvl) begin
        st_d.cnt   = '0;
        st_d.tx_on = 1'b0;
      end else if (sc_rise) begin
        sh         = {st_q.shreg[30:0], si_lvl};
        st_d.shreg = sh;
        if (st_q.cnt != dpsp_pkg::FULL_COUNT) begin
          st_d.cnt = st_q.cnt + 6'h01;
        end
        if (st_q.cnt == 6'h00) begin
          st_d.is_read = si_lvl;
        end
        if (st_q.cnt == 6'h06) begin
          a6        = sh[5:0];
          st_d.addr = a6;
        end
        if (st_q.is_read && st_q.cnt >= dpsp_pkg::LEG_DATA_FIRST &&
            st_q.cnt < dpsp_pkg::LEG_LAST_EDGE) begin
          st_d.tx_on = 1'b1;
          // load at the eighth rise, once the bank has seen the new address
          if (st_q.cnt == dpsp_pkg::LEG_DATA_FIRST) begin
            st_d.out = lw[23];
            st_d.tx  = {lw[22:0], 1'b0};
          end else begin
            st_d.out = st_q.tx[23];
            st_d.tx  = {st_q.tx[22:0], 1'b0};
          end
        end else begin
          st_d.tx_on = 1'b0;
        end
        if (st_q.cnt == (dpsp_pkg::LEG_LAST_EDGE - 6'h01) && !st_q.is_read) begin
          st_d.we    = 1'b1;
          st_d.wdata = sh[23:0];
          if (st_q.addr == {1'b0, dpsp_pkg::REG_ID_STROBE}) begin
            st_d.srst = sh[dpsp_pkg::SWRST_BIT];
          end
        end
      end
    end else begin
      // open protocol
      if (fs_rise) begin
        if (st_q.cnt == dpsp_pkg::FULL_COUNT &&
            st_q.shreg[2:0] == chip_addr) begin
          a5         = st_q.shreg[7:3];
          st_d.addr  = {1'b0, a5};
          st_d.wdata = st_q.shreg[31:8];
          st_d.we    = 1'b1;
          if (a5 == dpsp_pkg::REG_ID_STROBE) begin
            st_d.rd_addr = st_q.shreg[12:8];
            st_d.srst    = st_q.shreg[8 + dpsp_pkg::SWRST_BIT];
          end
        end
        st_d.cnt     = '0;
        st_d.tx_on   = 1'b0;
        st_d.drive_n = 1'b0;
      end else if (sc_rise && !fs_lvl) begin
        st_d.shreg = {st_q.shreg[30:0], si_lvl};
        if (st_q.cnt == 6'h00) begin
          st_d.tx = ow;
        end
        if (st_q.cnt != dpsp_pkg::FULL_COUNT) begin
          st_d.cnt = st_q.cnt + 6'h01;
        end
        st_d.tx_on = (st_q.cnt < dpsp_pkg::FULL_COUNT - 6'h01);
        if (st_q.cnt < 6'h18) begin
          st_d.out = (st_q.cnt == 6'h00) ? ow[23] : st_q.tx[22];
          if (st_q.cnt != 6'h00) begin
            st_d.tx = {st_q.tx[22:0], 1'b0};
          end
        end else begin
          st_d.out = 1'b0;
        end
        if (st_q.cnt == dpsp_pkg::FULL_COUNT - 6'h01) begin
          st_d.drive_n = ({st_q.shreg[1:0], si_lvl} != chip_addr);
        end
      end
    end

    // output line selection
    if (st_q.mode == dpsp_pkg::DPSP_UNDECIDED) begin
      st_d.oe_n = 1'b1;
    end else begin
      st_d.oe_n = st_d.drive_n;
    end
    if (!st_d.tx_on) begin
      st_d.out = lock_indicator;
    end
  end

  // ****************************************************
  // state register
  // ****************************************************
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q         <= '0;
      st_q.mode    <= dpsp_pkg::DPSP_UNDECIDED;
      st_q.oe_n    <= 1'b1;
      st_q.rd_addr <= dpsp_pkg::RD_ADDR_RESET;
    end else begin
      st_q <= st_d;
    end
  end

  assign serial_out      = st_q.out;
  assign serial_out_oe_n = st_q.oe_n;
  assign reg_addr        = st_q.addr;
  assign reg_wdata       = st_q.wdata;
  assign reg_we          = st_q.we;
  assign soft_reset      = st_q.srst;
  assign open_rd_addr    = st_q.rd_addr;
  assign proto_mode      = st_q.mode;

  // ****************************************************
  // checks
  // ****************************************************
  AST_MODE_STICKY: assert property (@(posedge clk) disable iff (!rst_n)
    $past(st_q.mode) != dpsp_pkg::DPSP_UNDECIDED |-> $stable(st_q.mode))
    else $error("protocol mode changed after commit");

  AST_LEGACY_PICK: assert property (@(posedge clk) disable iff (!rst_n)
    st_q.mode == dpsp_pkg::DPSP_UNDECIDED && fs_rise |=>
    st_q.mode == dpsp_pkg::DPSP_LEGACY)
    else $error("strobe first did not pick legacy");

  AST_OPEN_PICK: assert property (@(posedge clk) disable iff (!rst_n)
    st_q.mode == dpsp_pkg::DPSP_UNDECIDED && sc_rise && !fs_rise |=>
    st_q.mode == dpsp_pkg::DPSP_OPEN)
    else $error("clock first did not pick open");

  AST_LEG_WE_COUNT: assert property (@(posedge clk) disable iff (!rst_n)
    st_q.we && st_q.mode == dpsp_pkg::DPSP_LEGACY |->
    st_q.cnt == dpsp_pkg::LEG_LAST_EDGE && !st_q.is_read)
    else $error("legacy write not on 31st edge");

  AST_LOCK_RESTORE: assert property (@(posedge clk) disable iff (!rst_n)
    st_q.mode == dpsp_pkg::DPSP_LEGACY && st_q.cnt == dpsp_pkg::FULL_COUNT |->
    !st_q.tx_on)
    else $error("lock indicator not restored");

  AST_LOCK_BEFORE: assert property (@(posedge clk) disable iff (!rst_n)
    st_q.mode == dpsp_pkg::DPSP_LEGACY && st_q.cnt < 6'h08 |-> !st_q.tx_on)
    else $error("read data before eighth edge");

  AST_OPEN_COMMIT: assert property (@(posedge clk) disable iff (!rst_n)
    st_q.mode == dpsp_pkg::DPSP_OPEN && st_q.we |-> $past(fs_rise))
    else $error("open write without strobe rise");

  AST_SHORT_DROP: assert property (@(posedge clk) disable iff (!rst_n)
    st_q.mode == dpsp_pkg::DPSP_OPEN && fs_rise &&
    st_q.cnt != dpsp_pkg::FULL_COUNT |=> !st_q.we)
    else $error("short open frame was written");

  AST_LEG_READ_ON: assert property (@(posedge clk) disable iff (!rst_n)
    st_q.mode == dpsp_pkg::DPSP_LEGACY && fs_lvl && sc_rise && st_q.is_read &&
    st_q.cnt == dpsp_pkg::LEG_DATA_FIRST |=> st_q.tx_on)
    else $error("legacy read data not started on eighth edge");

  AST_LEG_SHORT: assert property (@(posedge clk) disable iff (!rst_n)
    st_q.mode == dpsp_pkg::DPSP_LEGACY && !fs_lvl |=> st_q.cnt == 6'h00 && !st_q.we)
    else $error("legacy frame state kept after strobe low");

  AST_RDADDR_LOAD: assert property (@(posedge clk) disable iff (!rst_n)
    st_q.mode == dpsp_pkg::DPSP_OPEN && st_q.we &&
    st_q.addr == {1'b0, dpsp_pkg::REG_ID_STROBE} |->
    st_q.rd_addr == st_q.wdata[4:0] && st_q.srst == st_q.wdata[dpsp_pkg::SWRST_BIT])
    else $error("open register 0 write not applied");

  AST_TRISTATE: assert property (@(posedge clk) disable iff (!rst_n)
    st_q.mode == dpsp_pkg::DPSP_OPEN && sc_rise && !fs_lvl &&
    st_q.cnt == (dpsp_pkg::FULL_COUNT - 6'h01) &&
    {st_q.shreg[1:0], si_lvl} != chip_addr |=> st_q.oe_n)
    else $error("foreign chip address still driven");

endmodule : dpsp_port
`default_nettype wire

/* File: src/dpsp_sync.sv */
// Purpose: two flip-flop synchroniser with edge outputs
// Assumes: input from outside the clock domain
// Notes:   only the second stage and later are read
`timescale 1ns/1ns
`default_nettype none
module dpsp_sync (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic pin,
  output logic      level,
  output logic      rise,
  output logic      fall
);

  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
  } dpsp_sync_t;

  dpsp_sync_t st_q;
  dpsp_sync_t st_d;

  // shift chain
  always_comb begin
    st_d    = st_q;
    st_d.s1 = pin;
    st_d.s2 = st_q.s1;
    st_d.s3 = st_q.s2;
  end

  // state register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  // edges seen after the second stage
  assign level = st_q.s2;
  assign rise  = st_q.s2 & ~st_q.s3;
  assign fall  = ~st_q.s2 & st_q.s3;

endmodule : dpsp_sync
`default_nettype wire

/* File: testbench/dpsp_host.sv */
// Purpose: host side model driving serial frames
// Assumes: bit period 80 ns, half period 40 ns
// Notes:   read bits sampled at end of low phase
`timescale 1ns/1ns
`default_nettype none
module dpsp_host (
  output var logic frame_strobe,
  output var logic serial_clk,
  output var logic serial_in,
  input  wire logic serial_out,
  input  wire logic serial_out_oe_n
);
  // ****************************************************
  // power-up and frames
  // ****************************************************
  // lines low at power-up
  task automatic power_up();
    frame_strobe = 1'b0;
    serial_clk   = 1'b0;
    serial_in    = 1'b0;
  endtask : power_up
  initial power_up();
  task automatic shift(input logic [31:0] w, input int n, input int first,
                       output logic [23:0] rd, output logic oe);
    rd = 24'h0;
    oe = 1'b1;
    serial_in = w[31];
    #40;
    for (int i = 0; i < n; i++) begin
      serial_clk = 1'b1;
      #40;
      serial_clk = 1'b0;
      if (i < 31) serial_in = w[30-i];
      if (i == n - 1) frame_strobe = 1'b0;
      #40;
      if (i >= first && i < first + 24) rd = {rd[22:0], serial_out};
      if (i == n - 1) oe = serial_out_oe_n; // chip address known after last rise
    end
    serial_in = ~serial_in; // released line
  endtask : shift
  // strobe rises with direction bit set
  task automatic legacy_frame(input logic dir, input logic [5:0] a, input logic [23:0] d,
                              input int n, output logic [23:0] rd);
    logic oe;
    frame_strobe = 1'b1;
    shift({dir, a, d, 1'b0}, n, 7, rd, oe);
    #80;
  endtask : legacy_frame
  task automatic open_frame(input logic [23:0] d, input logic [4:0] r, input logic [2:0] c,
                            input int n, output logic [23:0] rd, output logic oe);
    shift({d, r, c}, n, 0, rd, oe);
    #40;
    frame_strobe = 1'b1;
    #80;
    frame_strobe = 1'b0;
    #80;
  endtask : open_frame
endmodule : dpsp_host
`default_nettype wire

/* File: testbench/dual_protocol_serial_port_tb.sv */
// Purpose: self-checking bench for the serial port
// Assumes: external bank returns a fixed word
// Notes:   each mode needs its own power-down
`timescale 1ns/1ns
`default_nettype none
module dual_protocol_serial_port_tb;
  logic        clk, rst_n, lock_indicator, frame_strobe, serial_clk, serial_in;
  logic        serial_out, serial_out_oe_n, reg_we, soft_reset, oe;
  logic [23:0] reg_rdata, reg_wdata, rd;
  logic [2:0]  chip_addr;
  logic [5:0]  reg_addr;
  logic [4:0]  open_rd_addr;
  logic [1:0]  proto_mode;
  int          err_count, checked, we_cnt, sr_cnt;
  localparam logic [23:0] BANK = 24'h9b1e47;
  dpsp_port u_dut (.clk(clk), .rst_n(rst_n), .frame_strobe(frame_strobe),
    .serial_clk(serial_clk), .serial_in(serial_in), .lock_indicator(lock_indicator),
    .reg_rdata(reg_rdata), .chip_addr(chip_addr), .serial_out(serial_out),
    .serial_out_oe_n(serial_out_oe_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_we(reg_we), .soft_reset(soft_reset), .open_rd_addr(open_rd_addr),
    .proto_mode(proto_mode));
  dpsp_host u_host (.frame_strobe(frame_strobe), .serial_clk(serial_clk),
    .serial_in(serial_in), .serial_out(serial_out), .serial_out_oe_n(serial_out_oe_n));
  // ****************************************************
  // clock, pulse counters, helpers
  // ****************************************************
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // count write and soft reset pulses
  always @(posedge clk) begin
    if (reg_we === 1'b1) we_cnt++;
    if (soft_reset === 1'b1) sr_cnt++;
  end
  task automatic check(input string what, input logic [23:0] exp, input logic [23:0] got);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  task automatic do_reset();
    u_host.power_up();
    @(posedge clk) #1 rst_n = 1'b0;
    repeat (8) @(posedge clk);
    #1 rst_n = 1'b1;
    repeat (4) @(posedge clk);
    #1;
  endtask : do_reset
  task automatic end_of_test();
    $display("checked %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : end_of_test
  // ****************************************************
  // scenarios
  // ****************************************************
  task automatic test_legacy();
    int w0;
    do_reset();
    u_host.legacy_frame(1'b0, 6'h15, 24'ha5c33c, 32, rd);
    check("mode", 24'(dpsp_pkg::DPSP_LEGACY), 24'(proto_mode));
    check("we count", 24'h1, 24'(we_cnt));
    check("addr", 24'h15, 24'(reg_addr));
    check("wdata", 24'ha5c33c, reg_wdata);
    check("idle out", 24'h1, 24'(serial_out));
    // low lock level so the restored line differs from the last data bit
    lock_indicator = 1'b0;
    u_host.legacy_frame(1'b1, 6'h05, 24'h0, 32, rd);
    check("read data", BANK, rd);
    check("read no we", 24'h1, 24'(we_cnt));
    check("lock back", 24'h0, 24'(serial_out));
    u_host.legacy_frame(1'b1, 6'h00, 24'h0, 32, rd);
    check("id read", dpsp_pkg::CHIP_ID_RST, rd);
    u_host.legacy_frame(1'b0, 6'h00, 24'h000020, 32, rd);
    check("soft reset", 24'h1, 24'(sr_cnt));
    w0 = we_cnt;
    u_host.legacy_frame(1'b0, 6'h03, 24'h777777, 20, rd);
    check("short frame", 24'(w0), 24'(we_cnt));
    @(posedge clk) #1 lock_indicator = 1'b1;
    repeat (4) @(posedge clk);
    check("lock high", 24'h1, 24'(serial_out));
    $display("test_legacy done");
  endtask : test_legacy
  task automatic test_open();
    int w0;
    int s0;
    do_reset();
    @(posedge clk) #1 lock_indicator = 1'b1;
    u_host.open_frame(24'h0, 5'h00, 3'h0, 32, rd, oe);
    check("mode", 24'(dpsp_pkg::DPSP_OPEN), 24'(proto_mode));
    check("id out", dpsp_pkg::CHIP_ID_RST, rd);
    check("oe own", 24'h0, 24'(oe));
    u_host.open_frame(24'h000003, 5'h00, 3'h0, 32, rd, oe);
    check("rd addr", 24'h3, 24'(open_rd_addr));
    w0 = we_cnt;
    s0 = sr_cnt;
    u_host.open_frame(24'h5a0f96, 5'h07, 3'h0, 32, rd, oe);
    check("bank out", BANK, rd);
    check("we count", 24'(w0 + 1), 24'(we_cnt));
    check("addr", 24'h07, 24'(reg_addr));
    check("wdata", 24'h5a0f96, reg_wdata);
    u_host.open_frame(24'h000020, 5'h00, 3'h5, 32, rd, oe);
    check("oe foreign", 24'h1, 24'(oe));
    check("foreign we", 24'(w0 + 1), 24'(we_cnt));
    check("foreign sr", 24'(s0), 24'(sr_cnt));
    u_host.open_frame(24'h222222, 5'h0a, 3'h0, 20, rd, oe);
    check("short frame", 24'(w0 + 1), 24'(we_cnt));
    u_host.legacy_frame(1'b0, 6'h0a, 24'h333333, 32, rd);
    check("mode held", 24'(dpsp_pkg::DPSP_OPEN), 24'(proto_mode));
    check("no legacy we", 24'(w0 + 1), 24'(we_cnt));
    u_host.open_frame(24'h000020, 5'h00, 3'h0, 32, rd, oe);
    check("soft reset", 24'(s0 + 1), 24'(sr_cnt));
    $display("test_open done");
  endtask : test_open
  // ****************************************************
  // main sequence and watchdog
  // ****************************************************
  initial begin
    rst_n = 1'b0;
    lock_indicator = 1'b1;
    reg_rdata = BANK;
    chip_addr = dpsp_pkg::CHIP_ADDR_RST;
    test_legacy();
    test_open();
    end_of_test();
  end
  // frames take about 31 us in all
  initial begin
    #200000;
    err_count++;
    end_of_test();
  end
endmodule : dual_protocol_serial_port_tb
`default_nettype wire
